/* File: hdl/ccw_clock_ctrl.sv */
// How it works
// R01 - the three latched straps pick a multiplier: 111 x4, 110 x3, 101 x2, 100 x5, 011 x1, 010 x1.5, 001 x0.5, 000 x2.5.
// R02 - code 001 gives a 2:1 prescaler, each cpu half period lasting one input period.
// R03 - code 011 bypasses the pll and the cpu clock follows the input level directly.
// R04 - every other code runs the pll, giving the input frequency times the chosen factor.
// R05 - in pll mode the period reference is refreshed every F input periods (F rounded down, at least one), and only halfway each time.
// R06 - the oscillator watchdog is on after reset and off while software sets bit 4 of the config register.
// R07 - the watchdog supervises the direct and prescaler modes.
// R08 - an enabled watchdog keeps the pll free running, counts its clocks and clears on each input transition.
// R09 - 16 pll clocks with no input transition mean the input clock has failed.
// R10 - on failure the cpu clock moves to the free running pll clock and the failure flag is raised.
// R11 - after failure the cpu clock stays on the pll until a hardware reset.
// R12 - with the watchdog disabled in a direct mode before any failure, the pll is off and the input always clocks the cpu.
// R13 - the straps are read only around reset and the mode they give sources the cpu clock.
// R14 - the latched mode holds until the next reset whatever the strap pins do later.
// R15 - the failure flag stays until software clears it, and a later disable does not undo the switch.
module ccw_clock_ctrl
   import ccw_pkg::*;
#(
   parameter int CNT_W = 16
)
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [2:0] clockModeStrapPins,
   input wire logic clockInputPin,
   input wire logic pllFreeClkPin,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic cpuClk,
   output logic pllEnable,
   output logic clockFailIrq
);
   typedef struct packed {
      logic [2:0] inSync;
      logic inLvl;
      logic [2:0] pllSync;
      logic pllLvl;
      logic [8:0] strapSync;
      logic [1:0] settle;
      logic strapDone;
      logic [2:0] mode;
      ccw_src_t src;
      logic [CNT_W-1:0] period;
      logic [CNT_W-1:0] meas;
      logic [CNT_W-1:0] acc;
      logic [3:0] edges;
      logic cpuClk;
      logic wdogDis;
      logic clkFail;
      logic failMask;
      logic wrPend;
      logic [7:0] wrAddr;
      logic [31:0] rdata;
   } ccw_state_t;

   ccw_state_t s_reg;
   ccw_state_t s_next;
   ccw_wdog_if wdBus();

   logic inEdge;
   logic inRise;
   logic pllRise;
   logic addrPhase;
   logic [3:0] fx2;
   logic [CNT_W:0] accSum;
   logic [CNT_W:0] avg;
   logic [31:0] stateWord;

   // ==========================================
   // watchdog counter
   ccw_osc_watchdog u_ccw_osc_watchdog (
      .mclk(mclk),
      .arst_n(arst_n),
      .ce(ce),
      .wd(wdBus.wdog)
   );

   // supervision only where the cpu runs straight off the oscillator
   assign wdBus.enable = !s_reg.wdogDis && (s_reg.src == CCW_SRC_DIRECT ||
      s_reg.src == CCW_SRC_PRESCALE); // R06 R07
   assign wdBus.inEdge = inEdge;
   assign wdBus.pllTick = pllRise;

   // ==========================================
   // pin filtering
   // a pin change counts once the second and third stages agree
   always_comb begin
      inEdge = (s_reg.inSync[2] == s_reg.inSync[1]) && (s_reg.inSync[2] != s_reg.inLvl);
      inRise = inEdge && s_reg.inSync[2];
      pllRise = (s_reg.pllSync[2] == s_reg.pllSync[1]) && s_reg.pllSync[2] && !s_reg.pllLvl;
   end

   // ==========================================
   // pll model helpers
   assign fx2 = ccw_fx2(s_reg.mode); // R01
   assign accSum = {1'b0, s_reg.acc} + {{(CNT_W - 3){1'b0}}, fx2};
   // gradual retune: move only halfway toward the new measurement
   assign avg = ({1'b0, s_reg.period} + {1'b0, s_reg.meas}) >> 1; // R05

   // ==========================================
   // bus helpers
   assign addrPhase = hsel && htrans[1] && hready;
   // bit 6 reads zero, the pll state is visible on its own pin
   assign stateWord = {16'(s_reg.period), 4'h0,
      (wdBus.count != 5'h00), 2'h0, 1'b0,
      (s_reg.src == CCW_SRC_FAILED), 1'b0, s_reg.src, 1'b0, s_reg.mode};

   // ==========================================
   // next state
   always_comb begin
      s_next = s_reg;
      s_next.inSync = {s_reg.inSync[1:0], clockInputPin};
      s_next.pllSync = {s_reg.pllSync[1:0], pllFreeClkPin};
      s_next.strapSync = {s_reg.strapSync[5:0], clockModeStrapPins};
      if (s_reg.inSync[2] == s_reg.inSync[1]) begin
         s_next.inLvl = s_reg.inSync[2];
      end
      if (s_reg.pllSync[2] == s_reg.pllSync[1]) begin
         s_next.pllLvl = s_reg.pllSync[2];
      end

      // straps are caught once, only when the last two sync stages hold the same pin level
      if (!s_reg.strapDone) begin
         if (s_reg.settle != CCW_STRAP_SETTLE) begin
            s_next.settle = s_reg.settle + 2'h1;
         end else if (s_reg.strapSync[8:6] == s_reg.strapSync[5:3]) begin
            s_next.strapDone = 1'b1; // R14
            s_next.mode = s_reg.strapSync[8:6]; // R13
            case (s_reg.strapSync[8:6])
               CCW_MODE_PRESCALE: s_next.src = CCW_SRC_PRESCALE; // R02
               CCW_MODE_DIRECT: s_next.src = CCW_SRC_DIRECT; // R03
               default: s_next.src = CCW_SRC_PLL; // R04
            endcase
         end
      end
      // once caught, the mode never changes again until reset

      // cpu clock by source
      case (s_reg.src)
         CCW_SRC_DIRECT: begin
            s_next.cpuClk = s_reg.inLvl; // R03 R12
         end
         CCW_SRC_PRESCALE: begin
            if (inRise) begin
               s_next.cpuClk = !s_reg.cpuClk; // R02 R12
            end
         end
         CCW_SRC_FAILED: begin
            s_next.cpuClk = s_reg.pllLvl; // R10 R11
         end
         CCW_SRC_PLL: begin
            // fx2 toggles per input period, spread evenly
            if (s_reg.period == '0) begin
               s_next.acc = '0;
            end else if (accSum >= {1'b0, s_reg.period}) begin
               s_next.acc = CNT_W'(accSum - {1'b0, s_reg.period});
               s_next.cpuClk = !s_reg.cpuClk; // R04
            end else begin
               s_next.acc = accSum[CNT_W-1:0];
            end
         end
         default: begin
            s_next.cpuClk = 1'b0;
         end
      endcase

      // input period tracking for the multiplier
      if (inRise) begin
         // the edge cycle itself already belongs to the new period
         s_next.meas = CNT_W'(1);
         s_next.edges = s_reg.edges + 4'h1;
         if (s_reg.period == '0) begin
            s_next.period = s_reg.meas;
         end
         // input periods per resync are counted as rising edges
         if (s_reg.edges + 4'h1 >= (fx2 >> 1) || fx2 < 4'h2) begin
            s_next.edges = 4'h0;
            if (s_reg.period != '0) begin
               s_next.period = avg[CNT_W-1:0]; // R05
            end
         end
      end else if (s_reg.meas != {CNT_W{1'b1}}) begin
         s_next.meas = s_reg.meas + CNT_W'(1);
      end

      // failure switchover, no way back short of reset
      if (wdBus.overflow && wdBus.enable) begin
         s_next.src = CCW_SRC_FAILED; // R10 R11 R15
      end

      // bus write data phase
      s_next.wrPend = 1'b0;
      if (s_reg.wrPend) begin
         case (s_reg.wrAddr)
            CCW_OFS_SYSCFG: s_next.wdogDis = hwdata[CCW_BIT_WDOG_DIS]; // R06
            CCW_OFS_IRQSTAT: begin
               if (hwdata[CCW_BIT_CLKFAIL]) begin
                  s_next.clkFail = 1'b0; // R15
               end
            end
            CCW_OFS_IRQMASK: s_next.failMask = hwdata[CCW_BIT_CLKFAIL];
            default: ;
         endcase
      end
      // a failure in the clearing cycle still lands
      if (wdBus.overflow && wdBus.enable) begin
         s_next.clkFail = 1'b1; // R10 R15
      end

      // bus address phase
      if (addrPhase) begin
         s_next.wrPend = hwrite;
         s_next.wrAddr = {haddr[7:2], 2'b00};
         // read data stands until the next read, writes leave it alone
         if (!hwrite) begin
            s_next.rdata = 32'h0000_0000;
            case ({haddr[7:2], 2'b00})
               CCW_OFS_SYSCFG: s_next.rdata[CCW_BIT_WDOG_DIS] = s_reg.wdogDis;
               CCW_OFS_IRQSTAT: s_next.rdata[CCW_BIT_CLKFAIL] = s_reg.clkFail;
               CCW_OFS_IRQMASK: s_next.rdata[CCW_BIT_CLKFAIL] = s_reg.failMask;
               CCW_OFS_STATE: s_next.rdata = stateWord;
               default: s_next.rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
         s_reg.mode <= CCW_RST_MODE;
         s_reg.src <= CCW_SRC_PLL;
         s_reg.wdogDis <= CCW_RST_WDOG_DIS;
         s_reg.failMask <= CCW_RST_MASK;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   // ==========================================
   // outputs
   // pll runs for pll mode, for watchdog supervision, or after failure
   assign pllEnable = (s_reg.src == CCW_SRC_PLL) || (s_reg.src == CCW_SRC_FAILED) ||
      wdBus.enable; // R08 R12
   assign cpuClk = s_reg.cpuClk;
   assign clockFailIrq = s_reg.clkFail && s_reg.failMask;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;
endmodule

/* File: hdl/ccw_osc_watchdog.sv */
module ccw_osc_watchdog
   import ccw_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   ccw_wdog_if.wdog wd
);
   typedef struct packed {
      logic [4:0] cnt;
      logic ovf;
   } ccw_wd_state_t;

   ccw_wd_state_t s_reg;
   ccw_wd_state_t s_next;

   // ==========================================
   // counter
   always_comb begin
      s_next = s_reg;
      s_next.ovf = 1'b0;
      if (!wd.enable) begin
         s_next.cnt = 5'h00;
      end else if (wd.inEdge) begin
         s_next.cnt = 5'h00; // R08
      end else if (wd.pllTick && s_reg.cnt < 5'(CCW_WDOG_LIMIT)) begin
         s_next.cnt = s_reg.cnt + 5'h01; // R08
         // one pulse when the count reaches its limit
         s_next.ovf = (s_reg.cnt == 5'(CCW_WDOG_LIMIT - 1)); // R09
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign wd.overflow = s_reg.ovf;
   assign wd.count = s_reg.cnt;
endmodule

/* File: hdl/ccw_pkg.sv */
package ccw_pkg;
   // register byte offsets
   localparam logic [7:0] CCW_OFS_SYSCFG = 8'h00;
   localparam logic [7:0] CCW_OFS_IRQSTAT = 8'h04;
   localparam logic [7:0] CCW_OFS_IRQMASK = 8'h08;
   localparam logic [7:0] CCW_OFS_STATE = 8'h0c;
   // field positions
   localparam int CCW_BIT_WDOG_DIS = 4;
   localparam int CCW_BIT_CLKFAIL = 0;
   localparam int CCW_ST_MODE_LSB = 0;
   localparam int CCW_ST_SRC_LSB = 4;
   localparam int CCW_ST_PLLON = 6;
   localparam int CCW_ST_FAILED = 7;
   localparam int CCW_ST_PERIOD_LSB = 16;
   // reset values
   localparam logic CCW_RST_WDOG_DIS = 1'b0;
   localparam logic CCW_RST_MASK = 1'b0;
   localparam logic [2:0] CCW_RST_MODE = 3'h7;
   // strap codes
   localparam logic [2:0] CCW_MODE_PRESCALE = 3'h1;
   localparam logic [2:0] CCW_MODE_DIRECT = 3'h3;
   // timing counts
   localparam int CCW_WDOG_LIMIT = 16;
   localparam logic [1:0] CCW_STRAP_SETTLE = 2'h3;

   typedef enum logic [1:0] {
      CCW_SRC_PLL = 2'b00,
      CCW_SRC_DIRECT = 2'b01,
      CCW_SRC_PRESCALE = 2'b10,
      CCW_SRC_FAILED = 2'b11
   } ccw_src_t;

   // twice the multiplier, so 1.5, 0.5 and 2.5 stay integral
   function automatic logic [3:0] ccw_fx2(input logic [2:0] m);
      case (m)
         3'h7: ccw_fx2 = 4'h8;
         3'h6: ccw_fx2 = 4'h6;
         3'h5: ccw_fx2 = 4'h4;
         3'h4: ccw_fx2 = 4'ha;
         3'h3: ccw_fx2 = 4'h2;
         3'h2: ccw_fx2 = 4'h3;
         3'h1: ccw_fx2 = 4'h1;
         default: ccw_fx2 = 4'h5;
      endcase
   endfunction
endpackage

/* File: hdl/ccw_wdog_if.sv */
interface ccw_wdog_if;
   logic enable;
   logic inEdge;
   logic pllTick;
   logic overflow;
   logic [4:0] count;
   modport ctrl (output enable, output inEdge, output pllTick, input overflow, input count);
   modport wdog (input enable, input inEdge, input pllTick, output overflow, output count);
endinterface

/* File: tb/ccw_clock_ctrl_bench.sv */
// ==========
// bench
module ccw_clock_ctrl_bench;
   import ccw_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic [2:0] straps = 3'h7;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic run = 1'b1;
   logic hready, hreadyout, hresp, cpuClk, pllEnable, clockFailIrq, inPin, pllPin;
   logic [31:0] hrdata, rd;
   int n, checked = 0, bad_count = 0;
   int fx2[8] = '{5, 1, 3, 2, 10, 4, 6, 8};
   assign hready = hreadyout;
   always #2 mclk = ~mclk;
   ccw_osc_model u_ccw_osc_model (.run(run), .pllOn(pllEnable), .clockInputPin(inPin),
      .pllFreeClkPin(pllPin));
   ccw_clock_ctrl u_ccw_clock_ctrl (.mclk(mclk), .arst_n(arst_n), .ce(ce),
      .clockModeStrapPins(straps), .clockInputPin(inPin), .pllFreeClkPin(pllPin),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cpuClk(cpuClk), .pllEnable(pllEnable), .clockFailIrq(clockFailIrq));
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge mclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic startMode(input logic [2:0] m);
      arst_n <= 1'b0;
      straps <= m;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (6) @(posedge mclk);
   endtask
   task automatic toggles(input int cycles);
      logic last;
      last = cpuClk;
      n = 0;
      repeat (cycles) begin
         @(posedge mclk);
         if (cpuClk !== last) n++;
         last = cpuClk;
      end
   endtask
   task automatic readSrc(input logic [31:0] exp);
      xfer(1'b0, CCW_OFS_STATE, 32'h0);
      cmp("source", exp, {30'h0, rd[5:4]});
   endtask
   // ==========
   // scenarios
   task automatic testModes;
      for (int m = 0; m < 8; m++) begin
         startMode(3'(m));
         readSrc((m == 3) ? 32'h1 : (m == 1) ? 32'h2 : 32'h0);
         cmp("mode", 32'(m), {29'h0, rd[2:0]});
         cmp("pll on", 32'h1, {31'h0, pllEnable});
         straps <= ~3'(m);
         repeat (480) @(posedge mclk);
         // eight input periods, toggles are twice the factor each
         toggles(128);
         cmp("cpu rate", 32'h1, 32'(n >= fx2[m] * 7 && n <= fx2[m] * 9));
         xfer(1'b0, CCW_OFS_STATE, 32'h0);
         cmp("mode held", 32'(m), {29'h0, rd[2:0]});
         // input period is sixteen mclk cycles, smoothing may leave it one off
         cmp("period", 32'h1, 32'(rd[31:16] >= 16'h000f && rd[31:16] <= 16'h0011));
      end
      xfer(1'b0, CCW_OFS_SYSCFG, 32'h0);
      cmp("config reset", 32'h0, rd);
      xfer(1'b0, 8'h10, 32'h0);
      cmp("unmapped", 32'h0, rd);
      $display("modes done");
   endtask
   task automatic testFail;
      for (int k = 0; k < 2; k++) begin
         startMode(k ? CCW_MODE_PRESCALE : CCW_MODE_DIRECT);
         xfer(1'b1, CCW_OFS_IRQMASK, 32'h1);
         run <= 1'b0;
         n = 0;
         while (clockFailIrq !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
         end
         cmp("fail delay", 32'h1, 32'(n >= 85 && n <= 130));
         readSrc(32'h3);
         toggles(65);
         cmp("pll cpu clock", 32'h1, 32'(n >= 18 && n <= 22));
         xfer(1'b1, CCW_OFS_IRQMASK, 32'h0);
         @(posedge mclk);
         cmp("masked", 32'h0, {31'h0, clockFailIrq});
         xfer(1'b1, CCW_OFS_IRQMASK, 32'h1);
         @(posedge mclk);
         cmp("unmasked", 32'h1, {31'h0, clockFailIrq});
         run <= 1'b1;
         xfer(1'b1, CCW_OFS_SYSCFG, 32'h10);
         repeat (64) @(posedge mclk);
         readSrc(32'h3);
         cmp("pll kept", 32'h1, {31'h0, pllEnable});
         xfer(1'b1, CCW_OFS_IRQSTAT, 32'h1);
         @(posedge mclk);
         cmp("cleared", 32'h0, {31'h0, clockFailIrq});
      end
      startMode(CCW_MODE_DIRECT);
      readSrc(32'h1);
      $display("failure done");
   endtask
   task automatic testDisable;
      xfer(1'b1, CCW_OFS_SYSCFG, 32'h10);
      xfer(1'b0, CCW_OFS_SYSCFG, 32'h0);
      cmp("disable bit", 32'h10, rd);
      cmp("pll off", 32'h0, {31'h0, pllEnable});
      toggles(64);
      cmp("direct toggles", 32'h1, 32'(n >= 7 && n <= 9));
      run <= 1'b0;
      repeat (200) @(posedge mclk);
      cmp("direct level", {31'h0, inPin}, {31'h0, cpuClk});
      readSrc(32'h1);
      // pll modes are not supervised
      startMode(3'h7);
      repeat (200) @(posedge mclk);
      readSrc(32'h0);
      run <= 1'b1;
      $display("disable done");
   endtask
   task automatic summarize;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #100_000;
      bad_count++;
      summarize();
   end
   initial begin
      testModes();
      testFail();
      testDisable();
      summarize();
   end
endmodule

/* File: tb/ccw_clock_ctrl_sva.sv */
// ==========
// clock source checks
module ccw_clock_ctrl_sva (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic clockInputPin,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic cpuClk,
   input wire logic pllEnable,
   input wire logic clockFailIrq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // cycles since the last input transition, saturating
   logic [7:0] quietReg;
   logic sawFailReg;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         quietReg <= 8'h00;
         sawFailReg <= 1'b0;
      end else begin
         quietReg <= $changed(clockInputPin) ? 8'h00 : quietReg + {7'h0, quietReg != 8'hff};
         sawFailReg <= sawFailReg | clockFailIrq;
      end
   end
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_ready;
      hreadyout == 1'b1;
   endproperty
   a_ready: assert property (p_ready) else $error("wait state");
   property p_rdhold;
      !(ce && hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata);
   endproperty
   a_rdhold: assert property (p_rdhold) else $error("read data moved");
   // 16 pll edges need at least two cycles each through the sync
   property p_failquiet;
      $rose(clockFailIrq) |-> quietReg >= 8'h20;
   endproperty
   a_failquiet: assert property (p_failquiet) else $error("early failure");
   property p_irqpll;
      clockFailIrq |-> pllEnable;
   endproperty
   a_irqpll: assert property (p_irqpll) else $error("failed without pll");
   property p_failpll;
      sawFailReg |-> pllEnable;
   endproperty
   a_failpll: assert property (p_failpll) else $error("pll dropped after failure");
   property p_direct;
      !pllEnable && $changed(cpuClk) |-> $past(clockInputPin, 2) != $past(clockInputPin, 6);
   endproperty
   a_direct: assert property (p_direct) else $error("cpu clock not from input");
   property p_irqfall;
      $fell(clockFailIrq) |-> $past(hsel && htrans[1] && hwrite, 2);
   endproperty
   a_irqfall: assert property (p_irqfall) else $error("flag lost without write");
   c_fail: cover property ($rose(clockFailIrq));
   c_direct: cover property (!pllEnable && $changed(cpuClk));
   c_clear: cover property ($fell(clockFailIrq));
endmodule
bind ccw_clock_ctrl ccw_clock_ctrl_sva u_ccw_clock_ctrl_sva (.*);

/* File: tb/ccw_osc_model.sv */
// ==========
// crystal and pll free-running clock
module ccw_osc_model #(
   parameter int HALF_NS = 32,
   parameter int PLL_HALF_NS = 13
)
(
   input wire logic run,
   input wire logic pllOn,
   output logic clockInputPin,
   output logic pllFreeClkPin
);
   timeunit 1ns;
   timeprecision 100ps;
   // a dead crystal stands at its last level
   initial clockInputPin = 1'b0;
   always begin
      #(HALF_NS);
      if (run) clockInputPin = ~clockInputPin;
   end
   // pll gives no clock while switched off
   initial pllFreeClkPin = 1'b0;
   always begin
      #(PLL_HALF_NS);
      pllFreeClkPin = pllOn ? ~pllFreeClkPin : 1'b0;
   end
endmodule
